// [rtl/fac_map.svh]
`ifndef FAC_MAP_SVH
`define FAC_MAP_SVH
// register offsets (byte addresses, one word each)
`define FAC_ADDR_CTRL0 8'h00
`define FAC_ADDR_CTRL1 8'h04
`define FAC_ADDR_CTRL2 8'h08
`define FAC_CH_STRIDE 8'h20
`define FAC_OFF_CFG 8'h00
`define FAC_OFF_THR_HI 8'h04
`define FAC_OFF_THR_LO 8'h08
`define FAC_OFF_HYST 8'h0c
`define FAC_OFF_DELAY 8'h10
`define FAC_OFF_DUR 8'h14
`define FAC_OFF_STAT 8'h18
`define FAC_ADDR_TOT_PERM 8'h60
`define FAC_ADDR_TOT_RES 8'h64
`define FAC_ADDR_CMD 8'h68
// cfg fields
`define FAC_CFG_EN 0
`define FAC_CFG_FUNC_LSB 1
`define FAC_CFG_RSRC_LSB 3
`define FAC_CFG_TRIG_LSB 5
// cmd fields
`define FAC_CMD_MRST_LSB 0
`define FAC_CMD_TOTCLR 3
// reset values and limits
`define FAC_DELAY_DEF 24'd20
`define FAC_DELAY_MIN 24'd20
`define FAC_DUR_DEF 24'd500
`define FAC_DUR_MIN 24'd100
`define FAC_LIM_MAX 24'd9999999
`define FAC_HYST_FULL 8'd100
// 1 ms tick at 100 MHz: 1e6 ns / 10 ns
`define FAC_TICK_NS 1000000
`define FAC_CLK_NS 10
`define FAC_TICK_CYC (`FAC_TICK_NS / `FAC_CLK_NS)
`endif

// [rtl/fac_pkg.sv]
package fac_pkg;
   typedef enum logic [1:0] {
      FAC_FN_HIGH = 2'b00,
      FAC_FN_LOW = 2'b01,
      FAC_FN_WIN = 2'b10,
      FAC_FN_TOT = 2'b11
   } fac_func_e;
   typedef enum logic [1:0] {
      FAC_RS_MANUAL = 2'b00,
      FAC_RS_AUTO = 2'b01,
      FAC_RS_IN1 = 2'b10,
      FAC_RS_IN2 = 2'b11
   } fac_rsrc_e;
   typedef enum logic [2:0] {
      FAC_TR_RISE = 3'b000,
      FAC_TR_FALL = 3'b001,
      FAC_TR_BOTH = 3'b010,
      FAC_TR_HIGH = 3'b011,
      FAC_TR_LOW = 3'b100
   } fac_trig_e;
   typedef enum logic [1:0] {
      FAC_ST_IDLE = 2'b00,
      FAC_ST_DELAY = 2'b01,
      FAC_ST_ACTIVE = 2'b10
   } fac_state_e;
   typedef struct packed {
      logic en;
      fac_func_e func;
      fac_rsrc_e rsrc;
      fac_trig_e trig;
      logic [31:0] thr_hi;
      logic [31:0] thr_lo;
      logic [7:0] hyst;
      logic [23:0] delay;
      logic [23:0] dur;
      fac_state_e st;
      logic cond;
      logic [23:0] cnt;
      logic alarm;
   } fac_ch_s;
   typedef struct packed {
      fac_ch_s [2:0] ch;
      logic [1:0] in_s1;
      logic [1:0] in_s2;
      logic [1:0] in_prev;
      logic [16:0] tick_cnt;
      logic tick;
      logic [31:0] tot_perm;
      logic [31:0] tot_res;
      logic [31:0] rdata;
      logic [2:0] alarm_o;
   } fac_state_s;
endpackage

// [rtl/fac_flow_alarm.sv]
`timescale 1ns/1ps
`include "fac_map.svh"
module fac_flow_alarm
   import fac_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [31:0] flow_i,
   input wire logic [31:0] full_scale_i,
   input wire logic [31:0] flow_inc_i,
   input wire logic flow_inc_vld_i,
   input wire logic [1:0] reset_in_i,
   output logic [2:0] alarm_o
);
   fac_state_s s_reg;
   fac_state_s s_next;
   logic [2:0] tot_clr;
   logic [39:0] hyst_prod [3];
   logic [31:0] hyst_amt [3];

   // hysteresis band in flow units
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         hyst_prod[i] = 40'(full_scale_i) * 40'(s_reg.ch[i].hyst);
         hyst_amt[i] = 32'(hyst_prod[i] / 40'd100);
      end
   end

   always_comb
   begin
      logic [1:0] rise;
      logic [1:0] fall;
      logic [31:0] val;
      logic on_c;
      logic off_c;
      logic in_lvl;
      logic rst_ev;
      logic rst_hold;
      logic [7:0] base;
      rise = '0;
      fall = '0;
      val = '0;
      on_c = 1'b0;
      off_c = 1'b0;
      in_lvl = 1'b0;
      rst_ev = 1'b0;
      rst_hold = 1'b0;
      base = '0;
      tot_clr = '0;
      s_next = s_reg;
      // input synchroniser and edge detect
      s_next.in_s1 = reset_in_i;
      s_next.in_s2 = s_reg.in_s1;
      s_next.in_prev = s_reg.in_s2;
      rise = s_reg.in_s2 & ~s_reg.in_prev;
      fall = ~s_reg.in_s2 & s_reg.in_prev;
      // millisecond tick
      s_next.tick = 1'b0;
      if (s_reg.tick_cnt == 17'(`FAC_TICK_CYC - 1))
      begin
         s_next.tick_cnt = '0;
         s_next.tick = 1'b1;
      end
      else
      begin
         s_next.tick_cnt = s_reg.tick_cnt + 17'd1;
      end
      for (int i = 0; i < 3; i++)
      begin
         // condition with hysteresis
         val = (s_reg.ch[i].func == FAC_FN_TOT) ? s_reg.tot_res : flow_i;
         unique case (s_reg.ch[i].func)
            FAC_FN_HIGH:
            begin
               on_c = flow_i > s_reg.ch[i].thr_hi;
               off_c = {1'b0, flow_i} + {1'b0, hyst_amt[i]} <= {1'b0, s_reg.ch[i].thr_hi};
            end
            FAC_FN_LOW:
            begin
               on_c = flow_i < s_reg.ch[i].thr_hi;
               off_c = {1'b0, flow_i} >= {1'b0, s_reg.ch[i].thr_hi} + {1'b0, hyst_amt[i]};
            end
            FAC_FN_WIN:
            begin
               on_c = (flow_i > s_reg.ch[i].thr_hi) || (flow_i < s_reg.ch[i].thr_lo);
               off_c = ({1'b0, flow_i} + {1'b0, hyst_amt[i]} <= {1'b0, s_reg.ch[i].thr_hi})
                  && ({1'b0, flow_i} >= {1'b0, s_reg.ch[i].thr_lo} + {1'b0, hyst_amt[i]});
            end
            FAC_FN_TOT:
            begin
               on_c = val >= s_reg.ch[i].thr_hi;
               off_c = {1'b0, val} + {1'b0, hyst_amt[i]} < {1'b0, s_reg.ch[i].thr_hi};
            end
         endcase
         if (s_reg.ch[i].hyst >= `FAC_HYST_FULL)
         begin
            off_c = 1'b0;
         end
         if (!s_reg.ch[i].en)
         begin
            s_next.ch[i].cond = 1'b0;
         end
         else if (!s_reg.ch[i].cond && on_c)
         begin
            s_next.ch[i].cond = 1'b1;
         end
         else if (s_reg.ch[i].cond && off_c)
         begin
            s_next.ch[i].cond = 1'b0;
         end
         // reset source evaluation
         in_lvl = (s_reg.ch[i].rsrc == FAC_RS_IN2) ? s_reg.in_s2[1] : s_reg.in_s2[0];
         rst_ev = 1'b0;
         rst_hold = 1'b0;
         if (s_reg.ch[i].rsrc == FAC_RS_IN1 || s_reg.ch[i].rsrc == FAC_RS_IN2)
         begin
            unique case (s_reg.ch[i].trig)
               FAC_TR_RISE: rst_ev = (s_reg.ch[i].rsrc == FAC_RS_IN2) ? rise[1] : rise[0];
               FAC_TR_FALL: rst_ev = (s_reg.ch[i].rsrc == FAC_RS_IN2) ? fall[1] : fall[0];
               FAC_TR_BOTH:
                  rst_ev = (s_reg.ch[i].rsrc == FAC_RS_IN2) ? (rise[1] | fall[1])
                     : (rise[0] | fall[0]);
               FAC_TR_HIGH: rst_hold = in_lvl;
               FAC_TR_LOW: rst_hold = ~in_lvl;
               default: rst_ev = 1'b0;
            endcase
         end
         base = `FAC_CH_STRIDE * 8'(i);
         if (wr_i && addr_i == `FAC_ADDR_CMD && wdata_i[`FAC_CMD_MRST_LSB + i]
            && s_reg.ch[i].rsrc == FAC_RS_MANUAL)
         begin
            rst_ev = 1'b1;
         end
         // alarm sequencing
         if (!s_reg.ch[i].en || rst_hold)
         begin
            s_next.ch[i].st = FAC_ST_IDLE;
            s_next.ch[i].alarm = 1'b0;
            s_next.ch[i].cnt = '0;
         end
         else
         begin
            unique case (s_reg.ch[i].st)
               FAC_ST_IDLE:
               begin
                  s_next.ch[i].cnt = '0;
                  if (s_reg.ch[i].cond)
                  begin
                     s_next.ch[i].st = FAC_ST_DELAY;
                  end
               end
               FAC_ST_DELAY:
               begin
                  if (!s_reg.ch[i].cond)
                  begin
                     s_next.ch[i].st = FAC_ST_IDLE;
                     s_next.ch[i].cnt = '0;
                  end
                  else if (s_reg.tick)
                  begin
                     if (s_reg.ch[i].cnt + 24'd1 >= s_reg.ch[i].delay)
                     begin
                        s_next.ch[i].st = FAC_ST_ACTIVE;
                        s_next.ch[i].alarm = 1'b1;
                        s_next.ch[i].cnt = '0;
                     end
                     else
                     begin
                        s_next.ch[i].cnt = s_reg.ch[i].cnt + 24'd1;
                     end
                  end
               end
               FAC_ST_ACTIVE:
               begin
                  if (s_reg.ch[i].rsrc == FAC_RS_AUTO)
                  begin
                     if (s_reg.tick && s_reg.ch[i].cnt < s_reg.ch[i].dur)
                     begin
                        s_next.ch[i].cnt = s_reg.ch[i].cnt + 24'd1;
                     end
                     if (!s_reg.ch[i].cond && s_reg.ch[i].cnt >= s_reg.ch[i].dur)
                     begin
                        s_next.ch[i].st = FAC_ST_IDLE;
                        s_next.ch[i].alarm = 1'b0;
                     end
                  end
                  else if (rst_ev)
                  begin
                     s_next.ch[i].st = FAC_ST_IDLE;
                     s_next.ch[i].alarm = 1'b0;
                  end
               end
               default:
               begin
                  s_next.ch[i].st = FAC_ST_IDLE;
                  s_next.ch[i].alarm = 1'b0;
               end
            endcase
         end
         if (s_reg.ch[i].en && s_reg.ch[i].func == FAC_FN_TOT
            && s_reg.ch[i].rsrc == FAC_RS_AUTO && s_reg.ch[i].alarm)
         begin
            tot_clr[i] = 1'b1;
         end
         // configuration writes
         if (wr_i)
         begin
            if (addr_i == base + `FAC_OFF_CFG)
            begin
               s_next.ch[i].en = wdata_i[`FAC_CFG_EN];
               s_next.ch[i].func = fac_func_e'(wdata_i[`FAC_CFG_FUNC_LSB +: 2]);
               s_next.ch[i].rsrc = fac_rsrc_e'(wdata_i[`FAC_CFG_RSRC_LSB +: 2]);
               if (wdata_i[`FAC_CFG_TRIG_LSB +: 3] <= 3'(FAC_TR_LOW))
               begin
                  s_next.ch[i].trig = fac_trig_e'(wdata_i[`FAC_CFG_TRIG_LSB +: 3]);
               end
            end
            if (addr_i == base + `FAC_OFF_THR_HI)
            begin
               s_next.ch[i].thr_hi = wdata_i;
            end
            if (addr_i == base + `FAC_OFF_THR_LO)
            begin
               s_next.ch[i].thr_lo = wdata_i;
            end
            if (addr_i == base + `FAC_OFF_HYST)
            begin
               s_next.ch[i].hyst = (wdata_i[7:0] > `FAC_HYST_FULL) ? `FAC_HYST_FULL
                  : wdata_i[7:0];
            end
            if (addr_i == base + `FAC_OFF_DELAY)
            begin
               s_next.ch[i].delay = (wdata_i[23:0] < `FAC_DELAY_MIN) ? `FAC_DELAY_MIN
                  : (wdata_i[23:0] > `FAC_LIM_MAX) ? `FAC_LIM_MAX : wdata_i[23:0];
            end
            if (addr_i == base + `FAC_OFF_DUR)
            begin
               s_next.ch[i].dur = (wdata_i[23:0] < `FAC_DUR_MIN) ? `FAC_DUR_MIN
                  : (wdata_i[23:0] > `FAC_LIM_MAX) ? `FAC_LIM_MAX : wdata_i[23:0];
            end
         end
      end
      // totalizers
      if (flow_inc_vld_i)
      begin
         s_next.tot_perm = s_reg.tot_perm + flow_inc_i;
      end
      if (|tot_clr || (wr_i && addr_i == `FAC_ADDR_CMD && wdata_i[`FAC_CMD_TOTCLR]))
      begin
         s_next.tot_res = '0;
      end
      else if (flow_inc_vld_i)
      begin
         s_next.tot_res = s_reg.tot_res + flow_inc_i;
      end
      for (int i = 0; i < 3; i++)
      begin
         s_next.alarm_o[i] = s_next.ch[i].alarm;
      end
      // read port
      s_next.rdata = '0;
      if (rd_i)
      begin
         for (int i = 0; i < 3; i++)
         begin
            base = `FAC_CH_STRIDE * 8'(i);
            if (addr_i == base + `FAC_OFF_CFG)
            begin
               s_next.rdata = {24'h0, s_reg.ch[i].trig, s_reg.ch[i].rsrc,
                  s_reg.ch[i].func, s_reg.ch[i].en};
            end
            if (addr_i == base + `FAC_OFF_THR_HI) s_next.rdata = s_reg.ch[i].thr_hi;
            if (addr_i == base + `FAC_OFF_THR_LO) s_next.rdata = s_reg.ch[i].thr_lo;
            if (addr_i == base + `FAC_OFF_HYST) s_next.rdata = {24'h0, s_reg.ch[i].hyst};
            if (addr_i == base + `FAC_OFF_DELAY) s_next.rdata = {8'h0, s_reg.ch[i].delay};
            if (addr_i == base + `FAC_OFF_DUR) s_next.rdata = {8'h0, s_reg.ch[i].dur};
            if (addr_i == base + `FAC_OFF_STAT)
            begin
               s_next.rdata = {28'h0, s_reg.ch[i].st, s_reg.ch[i].cond, s_reg.ch[i].alarm};
            end
         end
         if (addr_i == `FAC_ADDR_TOT_PERM) s_next.rdata = s_reg.tot_perm;
         if (addr_i == `FAC_ADDR_TOT_RES) s_next.rdata = s_reg.tot_res;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         s_reg <= '0;
         for (int i = 0; i < 3; i++)
         begin
            s_reg.ch[i].func <= FAC_FN_HIGH;
            s_reg.ch[i].rsrc <= FAC_RS_MANUAL;
            s_reg.ch[i].trig <= FAC_TR_FALL;
            s_reg.ch[i].delay <= `FAC_DELAY_DEF;
            s_reg.ch[i].dur <= `FAC_DUR_DEF;
         end
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign rdata_o = s_reg.rdata;
   assign alarm_o = s_reg.alarm_o;
endmodule // fac_flow_alarm

// [tb/fac_flow_alarm_props.sv]
`timescale 1ns/1ps
`include "fac_map.svh"
module fac_flow_alarm_props
   import fac_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [31:0] flow_i,
   input wire logic [31:0] full_scale_i,
   input wire logic [31:0] flow_inc_i,
   input wire logic flow_inc_vld_i,
   input wire logic [1:0] reset_in_i,
   input wire logic [2:0] alarm_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);
   // cycles since reset release, saturating
   logic [21:0] age_reg;
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
         age_reg <= 22'h0;
      else if (age_reg != 22'h3fffff)
         age_reg <= age_reg + 22'h1;
   end
   sequence s_rd_ch(logic [4:0] off);
      rd_i && (addr_i < `FAC_ADDR_TOT_PERM) && (addr_i[4:0] == off);
   endsequence
   property p_rdata_idle;
      !$past(rd_i) |-> rdata_o == 32'h0;
   endproperty
   property p_unmapped;
      rd_i && (addr_i > `FAC_ADDR_CMD) |=> rdata_o == 32'h0;
   endproperty
   property p_delay_rng;
      s_rd_ch(5'h10) |=> rdata_o >= 32'h14 && rdata_o <= 32'h98967f;
   endproperty
   property p_dur_rng;
      s_rd_ch(5'h14) |=> rdata_o >= 32'h64 && rdata_o <= 32'h98967f;
   endproperty
   property p_hyst_rng;
      s_rd_ch(5'h0c) |=> rdata_o <= 32'h64;
   endproperty
   property p_trig_rng;
      s_rd_ch(5'h00) |=> rdata_o[7:5] <= 3'h4;
   endproperty
   property p_stat_rsv;
      s_rd_ch(5'h18) |=> rdata_o[31:4] == 28'h0 && rdata_o[3:2] != 2'h3;
   endproperty
   property p_rst_clr;
      disable iff (1'b0) srst_i |=> alarm_o == 3'h0 && rdata_o == 32'h0;
   endproperty
   property p_alarm_early;
      age_reg < 22'd1900000 |-> alarm_o == 3'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_delay_rng: assert property (p_delay_rng) else $error("delay out of range");
   a_dur_rng: assert property (p_dur_rng) else $error("duration out of range");
   a_hyst_rng: assert property (p_hyst_rng) else $error("hysteresis above full");
   a_trig_rng: assert property (p_trig_rng) else $error("trigger code invalid");
   a_stat_rsv: assert property (p_stat_rsv) else $error("status bits invalid");
   a_rst_clr: assert property (p_rst_clr) else $error("outputs not cleared by reset");
   a_alarm_early: assert property (p_alarm_early) else $error("alarm before delay");
endmodule // fac_flow_alarm_props
bind fac_flow_alarm fac_flow_alarm_props props_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .flow_i(flow_i), .full_scale_i(full_scale_i), .flow_inc_i(flow_inc_i),
   .flow_inc_vld_i(flow_inc_vld_i), .reset_in_i(reset_in_i), .alarm_o(alarm_o));

// [tb/fac_flow_src_model.sv]
`timescale 1ns/1ps
module fac_flow_src_model (
   input wire logic clk_sys_i,
   output logic [31:0] flow_o,
   output logic [31:0] full_scale_o,
   output logic [31:0] flow_inc_o,
   output logic flow_inc_vld_o,
   output logic [1:0] reset_in_o
);
   initial
   begin
      flow_o = 32'h0;
      full_scale_o = 32'h3e8;
      flow_inc_o = 32'h0;
      flow_inc_vld_o = 1'b0;
      reset_in_o = 2'h3;
   end
   task automatic set_flow(input logic [31:0] v);
      @(posedge clk_sys_i);
      flow_o <= v;
   endtask
   // increment valid for n sampled edges, then data no longer meaningful
   task automatic pulse_inc(input int n, input logic [31:0] v);
      @(posedge clk_sys_i);
      flow_inc_vld_o <= 1'b1;
      flow_inc_o <= v;
      repeat (n) @(posedge clk_sys_i);
      flow_inc_vld_o <= 1'b0;
      flow_inc_o <= ~v;
   endtask
   // push button on an input: idle high, pressed low
   task automatic press_in(input int b);
      @(posedge clk_sys_i);
      reset_in_o[b] <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      reset_in_o[b] <= 1'b1;
   endtask
endmodule // fac_flow_src_model

// [tb/fac_flow_alarm_tb_top.sv]
`timescale 1ns/1ps
`include "fac_map.svh"
module fac_flow_alarm_tb_top;
   logic clk_sys_i;
   logic srst_i;
   logic [7:0] addr_i;
   logic [31:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [31:0] rdata_o;
   logic [31:0] flow_i;
   logic [31:0] full_scale_i;
   logic [31:0] flow_inc_i;
   logic flow_inc_vld_i;
   logic [1:0] reset_in_i;
   logic [2:0] alarm_o;
   logic [31:0] d;
   int error_cnt = 0;
   int compares = 0;
   fac_flow_alarm dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .flow_i(flow_i),
      .full_scale_i(full_scale_i), .flow_inc_i(flow_inc_i), .flow_inc_vld_i(flow_inc_vld_i),
      .reset_in_i(reset_in_i), .alarm_o(alarm_o));
   fac_flow_src_model src_u (.clk_sys_i(clk_sys_i), .flow_o(flow_i),
      .full_scale_o(full_scale_i), .flow_inc_o(flow_inc_i), .flow_inc_vld_o(flow_inc_vld_i),
      .reset_in_o(reset_in_i));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic test_done;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i);
      v = rdata_o;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] v;
      rd(a, v);
      chk(nm, e, v);
   endtask
   task automatic cond(input logic [7:0] ch, input logic [31:0] f, input logic e);
      logic [31:0] v;
      src_u.set_flow(f);
      repeat (4) @(posedge clk_sys_i);
      rd((ch << 5) + `FAC_OFF_STAT, v);
      chk("cond", {31'h0, e}, {31'h0, v[1]});
   endtask
   initial
   begin
      repeat (60000) @(posedge clk_sys_i);
      error_cnt++;
      test_done();
   end
   initial
   begin
      srst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h0;
      wdata_i = 32'h0;
      repeat (16) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      for (int c = 0; c < 3; c++)
      begin
         rdc(8'(c * 32), 32'h20, "cfg");
         rdc(8'(c * 32) + `FAC_OFF_DELAY, 32'h14, "delay");
         rdc(8'(c * 32) + `FAC_OFF_DUR, 32'h1f4, "dur");
         rdc(8'(c * 32) + `FAC_OFF_HYST, 32'h0, "hyst");
         rdc(8'(c * 32) + `FAC_OFF_STAT, 32'h0, "stat");
      end
      rdc(8'h1c, 32'h0, "gap");
      rdc(8'h7c, 32'h0, "unmapped");
      wr(`FAC_OFF_DELAY, 32'h5);
      rdc(`FAC_OFF_DELAY, 32'h14, "delay lo");
      wr(`FAC_OFF_DELAY, 32'hffffff);
      rdc(`FAC_OFF_DELAY, 32'h98967f, "delay hi");
      wr(`FAC_OFF_DUR, 32'h32);
      rdc(`FAC_OFF_DUR, 32'h64, "dur lo");
      wr(`FAC_OFF_HYST, 32'hc8);
      rdc(`FAC_OFF_HYST, 32'h64, "hyst hi");
      wr(8'h00, 32'ha0);
      rdc(8'h00, 32'h20, "trig bad");
      wr(`FAC_OFF_THR_HI, 32'hffffffff);
      rdc(`FAC_OFF_THR_HI, 32'hffffffff, "thr max");
      wr(8'h00, 32'h1);
      wr(`FAC_OFF_THR_HI, 32'h1f4);
      wr(`FAC_OFF_HYST, 32'ha);
      cond(0, 32'h1f5, 1'b1);
      cond(0, 32'h1c2, 1'b1);
      cond(0, 32'h190, 1'b0);
      cond(0, 32'h1c2, 1'b0);
      wr(`FAC_OFF_HYST, 32'h0);
      cond(0, 32'h1f4, 1'b0);
      wr(8'h00, 32'h3);
      cond(0, 32'h1f3, 1'b1);
      cond(0, 32'h1f4, 1'b0);
      wr(8'h00, 32'h5);
      wr(`FAC_OFF_THR_HI, 32'h5);
      wr(`FAC_OFF_THR_LO, 32'h4);
      cond(0, 32'h6, 1'b1);
      cond(0, 32'h5, 1'b0);
      cond(0, 32'h4, 1'b0);
      cond(0, 32'h3, 1'b1);
      wr(8'h00, 32'h1);
      wr(`FAC_OFF_THR_HI, 32'h1f4);
      wr(`FAC_OFF_HYST, 32'h64);
      cond(0, 32'h1f5, 1'b1);
      cond(0, 32'h0, 1'b1);
      cond(1, 32'h3e8, 1'b0);
      wr(8'h40, 32'h7);
      wr(8'h40 + `FAC_OFF_THR_HI, 32'h1e);
      src_u.pulse_inc(10, 32'h3);
      repeat (2) @(posedge clk_sys_i);
      rdc(`FAC_ADDR_TOT_PERM, 32'h1e, "perm");
      rdc(`FAC_ADDR_TOT_RES, 32'h1e, "res");
      cond(2, 32'h0, 1'b1);
      wr(8'h40 + `FAC_OFF_THR_HI, 32'h1f);
      cond(2, 32'h0, 1'b0);
      wr(`FAC_ADDR_CMD, 32'h8);
      rdc(`FAC_ADDR_TOT_RES, 32'h0, "res clr");
      rdc(`FAC_ADDR_TOT_PERM, 32'h1e, "perm kept");
      wr(8'h20, 32'h71);
      src_u.press_in(0);
      src_u.press_in(1);
      wr(`FAC_ADDR_CMD, 32'h7);
      repeat (3000) @(posedge clk_sys_i);
      chk("alarm", 32'h0, {29'h0, alarm_o});
      test_done();
   end
endmodule // fac_flow_alarm_tb_top
